// [serdes_regs_defines.vh]
// Register offsets, field positions and reset values of the serializer register bank.
`ifndef SERDES_REGS_DEFINES_VH
`define SERDES_REGS_DEFINES_VH
`define ADDR_RX_CHAN_A_BIT_MASK 6'h0a
`define ADDR_RX_CHAN_B_BYTE     6'h0b
`define ADDR_RX_CHAN_B_BIT_MASK 6'h0c
`define ADDR_TX_IRQ_ENABLE      6'h0d
`define ADDR_TX_IRQ_FLAGS       6'h0e
`define ADDR_TX_DATA            6'h0f
`define ADDR_TX_VALID           6'h10
`define ADDR_MODE_CTRL          6'h03
`define BIT_UNDERFLOW           3
`define BIT_OVERFLOW            2
`define BIT_DONE                1
`define BIT_EMPTY               0
`define BIT_TX_ENABLE           7
`define BIT_RX_ENABLE           6
`define RESET_BYTE              8'h00
`define RESET_VALID             8'hff
`define FLAG_FIELD              3:0
`define ALL_VALID               8'hff
`define BIT_CNT_MAX             3'h7
`define FIFO_DEPTH              4
`endif

// [tx_fifo.v]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module tx_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_r != DEPTH[AW:0]);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i)
  begin
    if (ce_i && push)
      mem[wr_ptr_r] <= in_data_i;
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end
    else if (ce_i)
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// [tx_shifter.v]
// Transmit shifter that sends valid bits least significant first.
`timescale 1ns/1ps
`include "serdes_regs_defines.vh"
module tx_shifter (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       ce_i,
  input  wire       bit_tick_i,
  input  wire       active_i,
  input  wire [7:0] load_data_i,
  input  wire [7:0] load_valid_i,
  input  wire       load_avail_i,
  output wire       load_take_o,
  output reg        tx_bit_o,
  output reg        tx_bit_valid_o,
  output reg        loaded_o,
  output reg        underflow_o,
  output reg        done_o
);
  reg [7:0] data_r;
  reg [7:0] valid_r;
  reg [2:0] cnt_r;
  reg       busy_r;
  reg       sent_one_r;
  reg       ended_r;
  wire      need_next;

  // The shifter wants a new byte when idle or on the last bit of the current byte.
  assign need_next   = active_i & bit_tick_i & (~busy_r | (cnt_r == `BIT_CNT_MAX));
  assign load_take_o = need_next & load_avail_i;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_r         <= `RESET_BYTE;
      valid_r        <= `RESET_BYTE;
      cnt_r          <= 3'h0;
      busy_r         <= 1'b0;
      sent_one_r     <= 1'b0;
      ended_r        <= 1'b0;
      tx_bit_o       <= 1'b0;
      tx_bit_valid_o <= 1'b0;
      loaded_o       <= 1'b0;
      underflow_o    <= 1'b0;
      done_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      loaded_o    <= 1'b0;
      underflow_o <= 1'b0;
      done_o      <= 1'b0;
      if (!active_i)
      begin
        busy_r         <= 1'b0;
        sent_one_r     <= 1'b0;
        ended_r        <= 1'b0;
        cnt_r          <= 3'h0;
        tx_bit_valid_o <= 1'b0;
      end
      else if (bit_tick_i)
      begin
        if (busy_r && cnt_r != `BIT_CNT_MAX)
        begin
          // Shift out the next bit, LSB first; the count holds the index of the bit sent.
          tx_bit_o       <= data_r[0];
          tx_bit_valid_o <= valid_r[0];
          data_r         <= {1'b0, data_r[7:1]};
          valid_r        <= {1'b0, valid_r[7:1]};
          cnt_r          <= cnt_r + 3'h1;
          sent_one_r     <= 1'b1;
          // The byte ends once no valid bits remain behind this one.
          busy_r         <= (valid_r[7:1] != 7'h00);
          ended_r        <= (valid_r[7:1] == 7'h00);
        end
        else if (load_avail_i)
        begin
          tx_bit_o       <= load_data_i[0];
          tx_bit_valid_o <= load_valid_i[0];
          data_r         <= {1'b0, load_data_i[7:1]};
          valid_r        <= {1'b0, load_valid_i[7:1]};
          cnt_r          <= 3'h0;
          busy_r         <= (load_valid_i[7:1] != 7'h00);
          ended_r        <= (load_valid_i[7:1] == 7'h00);
          sent_one_r     <= 1'b1;
          loaded_o       <= 1'b1;
        end
        else
        begin
          tx_bit_valid_o <= 1'b0;
          busy_r         <= 1'b0;
          ended_r        <= 1'b0;
          if (sent_one_r)
          begin
            underflow_o <= 1'b1;
            done_o      <= ended_r;
          end
        end
      end
    end
  end
endmodule

// [serdes_valid_and_tx_irq_regs.v]
// Register bank for receive valid masks, channel B data and transmit interrupt logic.
`timescale 1ns/1ps
`include "serdes_regs_defines.vh"
module serdes_valid_and_tx_irq_regs #(
  parameter FIFO_WIDTH = 16,
  parameter FIFO_AW    = 2
) (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       ce_i,
  input  wire [5:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  input  wire       tx_enable_i,
  input  wire       rx_enable_i,
  input  wire       rx_a_load_i,
  input  wire [7:0] rx_a_valid_i,
  input  wire       rx_b_load_i,
  input  wire [7:0] rx_b_data_i,
  input  wire [7:0] rx_b_valid_i,
  input  wire       bit_tick_i,
  output wire       tx_bit_o,
  output wire       tx_bit_valid_o,
  output wire       rx_a_all_valid_o,
  output wire       rx_b_all_valid_o,
  output wire       irq_o
);
  // ==========================================================================
  // Input synchronisers for mode pins.
  reg        tx_en_s1_r;
  reg        tx_en_s2_r;
  reg        rx_en_s1_r;
  reg        rx_en_s2_r;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_en_s1_r <= 1'b0;
      tx_en_s2_r <= 1'b0;
      rx_en_s1_r <= 1'b0;
      rx_en_s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      tx_en_s1_r <= tx_enable_i;
      tx_en_s2_r <= tx_en_s1_r;
      rx_en_s1_r <= rx_enable_i;
      rx_en_s2_r <= rx_en_s1_r;
    end
  end

  wire tx_mode;
  assign tx_mode = tx_en_s2_r;

  // ==========================================================================
  // Receive side registers.
  reg [7:0] rx_a_mask_r;
  reg [7:0] rx_b_byte_r;
  reg [7:0] rx_b_mask_r;

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_a_mask_r <= `RESET_BYTE;
      rx_b_byte_r <= `RESET_BYTE;
      rx_b_mask_r <= `RESET_BYTE;
    end
    else if (ce_i)
    begin
      if (rx_a_load_i)
        rx_a_mask_r <= rx_a_valid_i;
      if (rx_b_load_i)
      begin
        rx_b_byte_r <= rx_b_data_i;
        rx_b_mask_r <= rx_b_valid_i;
      end
    end
  end

  // All-valid flags that let the host skip the mask read.
  assign rx_a_all_valid_o = rx_en_s2_r & (rx_a_mask_r == `ALL_VALID);
  assign rx_b_all_valid_o = rx_en_s2_r & (rx_b_mask_r == `ALL_VALID);

  // ==========================================================================
  // Host write decode and transmit byte path.
  reg  [3:0] tx_irq_en_r;
  reg  [7:0] tx_valid_r;
  wire       wr_en;
  wire       wr_data;
  wire       rd_flags;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [FIFO_WIDTH-1:0] fifo_out;
  wire       shift_take;
  wire       ev_loaded;
  wire       ev_underflow;
  wire       ev_done;

  assign wr_en    = ce_i & reg_wr_i & (reg_addr_i == `ADDR_TX_IRQ_ENABLE);
  assign wr_data  = ce_i & reg_wr_i & (reg_addr_i == `ADDR_TX_DATA);
  assign rd_flags = ce_i & reg_rd_i & (reg_addr_i == `ADDR_TX_IRQ_FLAGS);

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_irq_en_r <= 4'h0;
      tx_valid_r  <= `RESET_VALID;
    end
    else if (ce_i && reg_wr_i)
    begin
      if (reg_addr_i == `ADDR_TX_IRQ_ENABLE)
        tx_irq_en_r <= reg_wdata_i[`FLAG_FIELD];
      else if (reg_addr_i == `ADDR_TX_VALID)
        tx_valid_r <= reg_wdata_i;
    end
  end

  // Written bytes queue here; a data register write pushes at the FIFO tail.
  tx_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .in_data_i   ({tx_valid_r, reg_wdata_i}),
    .in_valid_i  (wr_data),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (shift_take)
  );

  tx_shifter u_shift (
    .clk_sys_i      (clk_sys_i),
    .reset_n_i      (reset_n_i),
    .ce_i           (ce_i),
    .bit_tick_i     (bit_tick_i),
    .active_i       (tx_mode),
    .load_data_i    (fifo_out[7:0]),
    .load_valid_i   (fifo_out[15:8]),
    .load_avail_i   (fifo_out_valid),
    .load_take_o    (shift_take),
    .tx_bit_o       (tx_bit_o),
    .tx_bit_valid_o (tx_bit_valid_o),
    .loaded_o       (ev_loaded),
    .underflow_o    (ev_underflow),
    .done_o         (ev_done)
  );

  // ==========================================================================
  // Transmit status flags; a set in the same cycle as a read or data-write clear wins.
  reg  [3:0] tx_flags_r;
  reg  [3:0] flags_nxt;
  wire       ev_overflow;

  // A write while a byte still waits to load is an overflow; FIFO full drops it.
  assign ev_overflow = wr_data & (fifo_out_valid | ~fifo_in_ready);

  always @*
  begin
    flags_nxt = tx_flags_r;
    if (rd_flags)
    begin
      flags_nxt[`BIT_UNDERFLOW] = 1'b0;
      flags_nxt[`BIT_OVERFLOW]  = 1'b0;
      flags_nxt[`BIT_DONE]      = 1'b0;
    end
    if (wr_data)
      flags_nxt[`BIT_EMPTY] = 1'b0;
    if (ev_underflow)
      flags_nxt[`BIT_UNDERFLOW] = 1'b1;
    if (ev_overflow)
      flags_nxt[`BIT_OVERFLOW] = 1'b1;
    if (ev_done)
      flags_nxt[`BIT_DONE] = 1'b1;
    if (ev_loaded)
      flags_nxt[`BIT_EMPTY] = 1'b1;
    if (!tx_mode)
      flags_nxt = 4'h0;
  end

  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      tx_flags_r <= 4'h0;
    else if (ce_i)
      tx_flags_r <= flags_nxt;
  end

  assign irq_o = |(tx_flags_r & tx_irq_en_r);

  // ==========================================================================
  // Read data mux.
  always @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= `RESET_BYTE;
    else if (ce_i && reg_rd_i)
    begin
      if (reg_addr_i == `ADDR_RX_CHAN_A_BIT_MASK)
        reg_rdata_o <= rx_en_s2_r ? rx_a_mask_r : `RESET_BYTE;
      else if (reg_addr_i == `ADDR_RX_CHAN_B_BYTE)
        reg_rdata_o <= rx_b_byte_r;
      else if (reg_addr_i == `ADDR_RX_CHAN_B_BIT_MASK)
        reg_rdata_o <= rx_en_s2_r ? rx_b_mask_r : `RESET_BYTE;
      else if (reg_addr_i == `ADDR_TX_IRQ_ENABLE)
        reg_rdata_o <= {4'h0, tx_irq_en_r};
      else if (reg_addr_i == `ADDR_TX_IRQ_FLAGS)
        reg_rdata_o <= {4'h0, tx_flags_r};
      else if (reg_addr_i == `ADDR_TX_VALID)
        reg_rdata_o <= tx_valid_r;
      else
        reg_rdata_o <= `RESET_BYTE;
    end
  end
endmodule

// [serdes_regs_checker.sv]
// Port-level assertions for the serializer register bank.
`timescale 1ns/1ps
module serdes_regs_checker (
  input wire       clk_sys_i,
  input wire       reset_n_i,
  input wire       ce_i,
  input wire [5:0] reg_addr_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       tx_enable_i,
  input wire       rx_enable_i,
  input wire       rx_a_load_i,
  input wire [7:0] rx_a_valid_i,
  input wire       rx_b_load_i,
  input wire [7:0] rx_b_data_i,
  input wire [7:0] rx_b_valid_i,
  input wire       bit_tick_i,
  input wire       tx_bit_o,
  input wire       tx_bit_valid_o,
  input wire       rx_a_all_valid_o,
  input wire       rx_b_all_valid_o,
  input wire       irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_rdata_holds: assert property (!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_b_byte_read: assert property (ce_i && rx_b_load_i ##1 !rx_b_load_i ##1 ce_i && reg_rd_i && reg_addr_i == 6'h0b
    |=> reg_rdata_o == $past(rx_b_data_i, 3))
    else $error("channel B byte read back wrong");
  a_b_not_all: assert property (ce_i && rx_b_load_i && rx_b_valid_i != 8'hff |=> !rx_b_all_valid_o)
    else $error("channel B all-valid with a partial mask");
  a_a_all_set: assert property (rx_enable_i [*3] ##0 ce_i && rx_a_load_i && rx_a_valid_i == 8'hff
    |=> rx_a_all_valid_o)
    else $error("channel A all-valid missing");
  a_enable_upper: assert property (ce_i && reg_rd_i && reg_addr_i == 6'h0d |=> reg_rdata_o[7:4] == 4'h0)
    else $error("enable reserved bits read nonzero");
  a_flags_upper: assert property (ce_i && reg_rd_i && reg_addr_i == 6'h0e |=> reg_rdata_o[7:4] == 4'h0)
    else $error("flag reserved bits read nonzero");
  a_flags_off_tx: assert property (!tx_enable_i [*4] ##0 ce_i && reg_rd_i && reg_addr_i == 6'h0e
    |=> reg_rdata_o == 8'h00)
    else $error("transmit flags nonzero outside transmit mode");
  a_irq_off_tx: assert property (!tx_enable_i [*4] |-> !irq_o)
    else $error("interrupt outside transmit mode");
  a_irq_masked: assert property (ce_i && reg_wr_i && reg_addr_i == 6'h0d && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
    else $error("interrupt with all enables off");
  a_bit_on_tick: assert property ($rose(tx_bit_valid_o) |-> $past(bit_tick_i))
    else $error("serial bit started without a bit tick");
endmodule

bind serdes_valid_and_tx_irq_regs serdes_regs_checker chk (.*);

// [radio_side_model.sv]
// Radio-side model: paces transmit bit times and collects the serial byte.
`timescale 1ns/1ps
module radio_side_model (
  input  wire        clk_sys_i,
  input  wire        tick_en_i,
  input  wire        tx_bit_i,
  input  wire        tx_bit_valid_i,
  output logic       bit_tick_o,
  output logic [7:0] bits_o,
  output logic [3:0] count_o
);
  logic [1:0] div    = 2'h0;
  logic       tick_d = 1'b0;
  initial
  begin
    bit_tick_o = 1'b0;
    bits_o = 8'h00;
    count_o = 4'h0;
  end
  always @(posedge clk_sys_i)
  begin
    div <= div + 2'h1;
    tick_d <= bit_tick_o;
    bit_tick_o <= #1 tick_en_i && div == 2'h3;
    if (tick_d && tx_bit_valid_i)
    begin
      bits_o <= {tx_bit_i, bits_o[7:1]};
      count_o <= count_o + 4'h1;
    end
  end
endmodule

// [serdes_valid_and_tx_irq_regs_test.sv]
// Self-checking bench for the serializer register bank and its transmit flags.
`timescale 1ns/1ps
module serdes_valid_and_tx_irq_regs_test;
  logic       clk_sys_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       wr_stb = 1'b0, rd_stb = 1'b0, tx_en = 1'b0, rx_en = 1'b0;
  logic       a_ld = 1'b0, b_ld = 1'b0, tick_en = 1'b0, ce = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00, a_msk = 8'h00, b_dat = 8'h00, b_msk = 8'h00;
  logic [7:0] rdata, bits;
  logic [3:0] nbits;
  logic       tick, tx_bit, tx_vld, a_all, b_all, irq;
  logic [5:0] reset_addrs [5] = '{6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h3f};
  int         miscompares = 0;
  int         check_count = 0;

  initial
    forever #25 clk_sys_i = ~clk_sys_i;

  serdes_valid_and_tx_irq_regs DUT (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr_stb),
    .reg_rd_i(rd_stb), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .tx_enable_i(tx_en), .rx_enable_i(rx_en),
    .rx_a_load_i(a_ld), .rx_a_valid_i(a_msk), .rx_b_load_i(b_ld), .rx_b_data_i(b_dat), .rx_b_valid_i(b_msk),
    .bit_tick_i(tick), .tx_bit_o(tx_bit), .tx_bit_valid_o(tx_vld), .rx_a_all_valid_o(a_all),
    .rx_b_all_valid_o(b_all), .irq_o(irq));

  radio_side_model far_end (
    .clk_sys_i(clk_sys_i), .tick_en_i(tick_en), .tx_bit_i(tx_bit), .tx_bit_valid_i(tx_vld),
    .bit_tick_o(tick), .bits_o(bits), .count_o(nbits));

  // ============================================================
  // Register access and checking
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1 addr = a;
    wdata = d;
    wr_stb = 1'b1;
    @(posedge clk_sys_i);
    #1 wr_stb = 1'b0;
  endtask

  task reg_read(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    #1 addr = a;
    rd_stb = 1'b1;
    @(posedge clk_sys_i);
    #1 rd_stb = 1'b0;
    chk(rdata, e);
  endtask

  task finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    rx_en = 1'b1;
    foreach (reset_addrs[i])
      reg_read(reset_addrs[i], 8'h00);
    reg_write(6'h0d, 8'h0f);
    reg_read(6'h0d, 8'h0f);
    reg_write(6'h0d, 8'h00);
    ce = 1'b0;
    reg_write(6'h0d, 8'h0f);
    ce = 1'b1;
    reg_read(6'h0d, 8'h00);
    a_msk = 8'hff;
    b_dat = 8'h5a;
    b_msk = 8'h3c;
    a_ld = 1'b1;
    b_ld = 1'b1;
    @(posedge clk_sys_i);
    #1 a_ld = 1'b0;
    b_ld = 1'b0;
    chk({7'h00, a_all}, 8'h01);
    chk({7'h00, b_all}, 8'h00);
    reg_read(6'h0b, 8'h5a);
    reg_read(6'h0c, 8'h3c);
    reg_read(6'h0a, 8'hff);
    b_msk = 8'hff;
    b_ld = 1'b1;
    @(posedge clk_sys_i);
    #1 b_ld = 1'b0;
    chk({7'h00, b_all}, 8'h01);
    tx_en = 1'b1;
    tick_en = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    #1 tick_en = 1'b0;
    reg_write(6'h10, 8'hff);
    reg_read(6'h0e, 8'h00);
    reg_write(6'h0f, 8'ha5);
    reg_read(6'h0e, 8'h00);
    tick_en = 1'b1;
    for (int i = 0; i < 300 && nbits !== 4'h8; i++)
      @(posedge clk_sys_i);
    if (nbits !== 4'h8)
    begin
      miscompares++;
      finish_test;
    end
    repeat (8) @(posedge clk_sys_i);
    #1 tick_en = 1'b0;
    chk(bits, 8'ha5);
    repeat (4) @(posedge clk_sys_i);
    chk({7'h00, irq}, 8'h00);
    reg_read(6'h0e, 8'h0b);
    reg_read(6'h0e, 8'h01);
    reg_write(6'h0f, 8'h11);
    reg_write(6'h0f, 8'h22);
    reg_write(6'h0d, 8'h04);
    chk({7'h00, irq}, 8'h01);
    reg_read(6'h0e, 8'h04);
    chk({7'h00, irq}, 8'h00);
    tx_en = 1'b0;
    rx_en = 1'b0;
    reg_write(6'h0f, 8'h33);
    repeat (3) @(posedge clk_sys_i);
    reg_read(6'h0e, 8'h00);
    chk({7'h00, a_all}, 8'h00);
    reg_read(6'h0a, 8'h00);
    finish_test;
  end
endmodule
